// File: pkg/uss_pkg.sv
// Purpose: shared constants and types for the synchronous slave serial port
// Assumes: avalon-mm register bus, word-aligned registers at 4 x index
// Notes:   offsets are register indices; byte address is index times four

package uss_pkg;

   // ----------------------------------------------------------------------
   // register indices
   // ----------------------------------------------------------------------
   localparam logic [7:0] IDX_INTERRUPT_CONTROL         = 8'h0B;
   localparam logic [7:0] IDX_PERIPHERAL_FLAGS_ONE      = 8'h0C;
   localparam logic [7:0] IDX_RECEIVE_STATUS_CONTROL    = 8'h18;
   localparam logic [7:0] IDX_TRANSMIT_BUFFER           = 8'h19;
   localparam logic [7:0] IDX_RECEIVE_FIFO_DATA         = 8'h1A;
   localparam logic [7:0] IDX_PERIPHERAL_ENABLES_ONE    = 8'h8C;
   localparam logic [7:0] IDX_TRANSMIT_STATUS_CONTROL   = 8'h98;
   localparam logic [7:0] IDX_BAUD_DIVISOR              = 8'h99;
   localparam logic [7:0] IDX_POWER_CONTROL             = 8'hF0;

   // ----------------------------------------------------------------------
   // field positions
   // ----------------------------------------------------------------------
   localparam int BIT_GLOBAL_INT_EN   = 7;
   localparam int BIT_PERIPH_INT_EN   = 6;
   localparam int BIT_RX_READY        = 5;
   localparam int BIT_TX_EMPTY        = 4;
   localparam int BIT_SERIAL_PORT_EN  = 7;
   localparam int BIT_RX_NINE_EN      = 6;
   localparam int BIT_SINGLE_RX_EN    = 5;
   localparam int BIT_CONT_RX_EN      = 4;
   localparam int BIT_ADDR_DETECT_EN  = 3;
   localparam int BIT_FRAMING_ERR     = 2;
   localparam int BIT_OVERRUN_ERR     = 1;
   localparam int BIT_RX_NINTH        = 0;
   localparam int BIT_CLK_SOURCE_SEL  = 7;
   localparam int BIT_TX_NINE_EN      = 6;
   localparam int BIT_TX_EN           = 5;
   localparam int BIT_SYNC_MODE       = 4;
   localparam int BIT_HIGH_BAUD       = 2;
   localparam int BIT_SHIFT_EMPTY     = 1;
   localparam int BIT_TX_NINTH        = 0;
   localparam int BIT_SLEEP           = 0;

   // ----------------------------------------------------------------------
   // reset values, interrupt vector and fifo depth
   // ----------------------------------------------------------------------
   localparam logic [7:0] RST_INTERRUPT_CONTROL       = 8'h00;
   localparam logic [7:0] RST_RECEIVE_STATUS_CONTROL  = 8'h00;
   localparam logic [7:0] RST_PERIPHERAL_ENABLES_ONE  = 8'h00;
   localparam logic [7:0] RST_TRANSMIT_STATUS_CONTROL = 8'h02;
   localparam logic [7:0] RST_BAUD_DIVISOR            = 8'h00;
   localparam logic [7:0] RST_DATA                    = 8'h00;
   localparam logic [7:0] INTERRUPT_VECTOR            = 8'h04;
   localparam int         FIFO_DEPTH                  = 2;

   // one received entry: data plus its ninth bit
   typedef struct packed {
      logic       ninth;
      logic [7:0] data;
   } uss_word_t;

   // edge events of the sampled shift clock
   typedef struct packed {
      logic rise;
      logic fall;
   } uss_edge_t;

endpackage

// File: design/uss_clk_sync.sv
// Purpose: two-stage synchroniser and edge finder for the external shift clock
// Assumes: clock line is asynchronous to clk
// Notes:   first stage feeds only the second stage

`timescale 1ns/1ps
`default_nettype none

module uss_clk_sync
   import uss_pkg::*;
(
   input  wire logic       clk,
   input  wire logic       resetn,
   input  wire logic       line_in,
   output var  uss_edge_t  edges,
   output logic            level
);

   logic meta_reg;
   logic sync_reg;
   logic prev_reg;

   // two flops then a delayed copy for edge finding
   // reset to the idle-low line level so no false edge follows reset
   always_ff @(posedge clk or negedge resetn) begin
      if (!resetn) begin
         meta_reg <= 1'b0;
         sync_reg <= 1'b0;
         prev_reg <= 1'b0;
      end else begin
         meta_reg <= line_in;
         sync_reg <= meta_reg;
         prev_reg <= sync_reg;
      end
   end

   // edges only ever look at settled stages
   assign edges.rise = sync_reg & ~prev_reg;
   assign edges.fall = ~sync_reg & prev_reg;
   assign level      = sync_reg;

endmodule

`default_nettype wire

// File: design/uss_rx_fifo.sv
// Purpose: receive fifo holding data plus ninth bit
// Assumes: push never offered when full (caller checks)
// Notes:   head entry is visible combinationally

`timescale 1ns/1ps
`default_nettype none

module uss_rx_fifo
   import uss_pkg::*;
#(
   parameter int DEPTH = FIFO_DEPTH
)(
   input  wire logic       clk,
   input  wire logic       resetn,
   input  wire logic       push,
   input  wire uss_word_t  push_word,
   input  wire logic       pop,
   output var  uss_word_t  head,
   output logic            empty,
   output logic            full
);

   localparam int AW = (DEPTH > 1) ? $clog2(DEPTH) : 1;

   // pointers wrap freely, so only powers of two are served
   if (DEPTH < 2 || (DEPTH & (DEPTH - 1)) != 0) begin : g_depth_check
      $error("uss_rx_fifo: DEPTH must be a power of two, at least 2");
   end

   uss_word_t       mem [DEPTH];
   logic [AW-1:0]   wr_ptr_reg;
   logic [AW-1:0]   rd_ptr_reg;
   logic [AW:0]     count_reg;

   assign empty = (count_reg == '0);
   assign full  = (count_reg == (AW+1)'(DEPTH));
   assign head  = mem[rd_ptr_reg];

   // storage; no reset needed on data
   always_ff @(posedge clk) begin
      if (push && !full)
         mem[wr_ptr_reg] <= push_word;
   end

   // pointers and fill count
   always_ff @(posedge clk or negedge resetn) begin
      if (!resetn) begin
         wr_ptr_reg <= '0;
         rd_ptr_reg <= '0;
         count_reg  <= '0;
      end else begin
         if (push && !full)
            wr_ptr_reg <= wr_ptr_reg + AW'(1);
         if (pop && !empty)
            rd_ptr_reg <= rd_ptr_reg + AW'(1);
         count_reg <= count_reg + (AW+1)'(push && !full) - (AW+1)'(pop && !empty);
      end
   end

endmodule

`default_nettype wire

// File: design/uss_sync_slave.sv
// Purpose: synchronous slave serial transceiver with avalon-mm registers
// Assumes: external master drives the shift clock; data changes after its fall
// Notes:   registers at byte address = index * 4; data in low 8 bits
//
// Added by the designer: the Avalon-MM register port.

`timescale 1ns/1ps
`default_nettype none

module uss_sync_slave
   import uss_pkg::*;
(
   input  wire logic        clk,
   input  wire logic        resetn,
   // avalon-mm slave
   input  wire logic [9:0]  avs_address,
   input  wire logic        avs_read,
   input  wire logic        avs_write,
   input  wire logic [31:0] avs_writedata,
   input  wire logic [3:0]  avs_byteenable,
   output logic [31:0]      avs_readdata,
   output logic             avs_waitrequest,
   // serial pins
   input  wire logic        shift_clk_in,
   input  wire logic        data_in,
   output logic             data_out,
   output logic             data_oe,
   // core power state and vector request
   output logic             sleeping,
   output logic             wake,
   output logic             irq_vector_req
);

   // ----------------------------------------------------------------------
   // registers and state
   // ----------------------------------------------------------------------
   logic [7:0]  interrupt_control_reg;
   logic [7:0]  pie_reg;
   logic [7:0]  receive_status_control_reg;      // control bits only; status is composed
   logic [7:0]  transmit_status_control_reg;      // control bits only
   logic [7:0]  baud_reg;
   logic        sleep_reg;
   logic [7:0]  txbuf_reg;
   logic        txbuf_ninth_reg;
   logic        txbuf_full_reg;
   logic [8:0]  tsr_reg;
   logic [3:0]  tx_cnt_reg;     // bits left in shifter, 0 = empty
   logic        tx_first_reg;   // first bit waits for a clock rise
   logic [8:0]  rsr_reg;
   logic [3:0]  rx_cnt_reg;
   logic        overrun_error_reg;
   logic        framing_error_reg;
   logic        wait_reg;
   logic [31:0] rdata_reg;
   logic        data_out_reg;
   logic        data_oe_reg;
   logic        wake_reg;
   logic        vec_reg;

   // ----------------------------------------------------------------------
   // clock synchronisers and receive fifo
   // ----------------------------------------------------------------------
   uss_edge_t   ck_edge;
   logic        dt_level;
   uss_word_t   fifo_head;
   logic        fifo_empty;
   logic        fifo_full;
   logic        fifo_push;
   logic        fifo_pop;
   uss_word_t   fifo_word;

   // external shift clock only; no internal baud generation here
   uss_clk_sync u_ck_sync (
      .clk     (clk),
      .resetn  (resetn),
      .line_in (shift_clk_in),
      .edges   (ck_edge),
      .level   ()
   );

   // data line crosses with the same two stages
   uss_clk_sync u_dt_sync (
      .clk     (clk),
      .resetn  (resetn),
      .line_in (data_in),
      .edges   (),
      .level   (dt_level)
   );

   uss_rx_fifo #(.DEPTH(FIFO_DEPTH)) u_fifo (
      .clk       (clk),
      .resetn    (resetn),
      .push      (fifo_push),
      .push_word (fifo_word),
      .pop       (fifo_pop),
      .head      (fifo_head),
      .empty     (fifo_empty),
      .full      (fifo_full)
   );

   // ----------------------------------------------------------------------
   // decode
   // ----------------------------------------------------------------------
   logic [7:0] idx;
   logic       bus_go;
   logic       wr_go;
   logic       rd_go;
   logic [7:0] wbyte;

   assign idx    = avs_address[9:2];
   // one wait state: request taken on the edge where waitrequest is low
   assign bus_go = (avs_read | avs_write) & ~wait_reg;
   assign wr_go  = bus_go & avs_write & avs_byteenable[0];
   assign rd_go  = bus_go & avs_read;
   assign wbyte  = avs_writedata[7:0];

   logic port_on;
   logic tx_on;
   logic rx_on;
   logic nine_tx;
   logic nine_rx;

   assign port_on = receive_status_control_reg[BIT_SERIAL_PORT_EN] & transmit_status_control_reg[BIT_SYNC_MODE]
                    & ~transmit_status_control_reg[BIT_CLK_SOURCE_SEL];
   assign tx_on   = port_on & transmit_status_control_reg[BIT_TX_EN];
   // single-receive enable deliberately not looked at
   assign rx_on   = port_on & receive_status_control_reg[BIT_CONT_RX_EN];
   assign nine_tx = transmit_status_control_reg[BIT_TX_NINE_EN];
   assign nine_rx = receive_status_control_reg[BIT_RX_NINE_EN];

   logic txbuf_wr;
   logic tx_load;

   assign txbuf_wr = wr_go && idx == IDX_TRANSMIT_BUFFER;
   // shifter loads from buffer as soon as it is empty, sleep or not
   assign tx_load  = tx_on && txbuf_full_reg && tx_cnt_reg == 4'h0;

   // ----------------------------------------------------------------------
   // bus handshake and read data
   // ----------------------------------------------------------------------
   // waitrequest drops for one cycle per request
   always_ff @(posedge clk or negedge resetn) begin
      if (!resetn) begin
         wait_reg <= 1'b1;
      end else begin
         wait_reg <= ~((avs_read | avs_write) & wait_reg);
      end
   end

   // read mux registered one cycle before the accepting edge
   // an empty fifo shows zeros, never a stale or unwritten entry
   always_ff @(posedge clk or negedge resetn) begin
      if (!resetn) begin
         rdata_reg <= 32'h0000_0000;
      end else begin
         unique case (idx)
            IDX_INTERRUPT_CONTROL:       rdata_reg <= {24'h0, interrupt_control_reg};
            IDX_PERIPHERAL_FLAGS_ONE:    rdata_reg <= {24'h0, 2'b00, ~fifo_empty,
                                                       ~txbuf_full_reg, 4'h0};
            IDX_RECEIVE_STATUS_CONTROL:  rdata_reg <= {24'h0, receive_status_control_reg[7:3], framing_error_reg, overrun_error_reg,
                                                       ~fifo_empty & fifo_head.ninth};
            IDX_RECEIVE_FIFO_DATA:       rdata_reg <= {24'h0, fifo_empty ? RST_DATA
                                                                : fifo_head.data};
            IDX_PERIPHERAL_ENABLES_ONE:  rdata_reg <= {24'h0, pie_reg};
            IDX_TRANSMIT_STATUS_CONTROL: rdata_reg <= {24'h0, transmit_status_control_reg[7:2],
                                                       tx_cnt_reg == 4'h0,
                                                       transmit_status_control_reg[BIT_TX_NINTH]};
            IDX_BAUD_DIVISOR:            rdata_reg <= {24'h0, baud_reg};
            IDX_POWER_CONTROL:           rdata_reg <= {31'h0, sleep_reg};
            default:                     rdata_reg <= 32'h0000_0000;
         endcase
      end
   end

   assign avs_readdata    = rdata_reg;
   assign avs_waitrequest = wait_reg;

   // ----------------------------------------------------------------------
   // control register writes
   // ----------------------------------------------------------------------
   always_ff @(posedge clk or negedge resetn) begin
      if (!resetn) begin
         interrupt_control_reg <= RST_INTERRUPT_CONTROL;
         pie_reg    <= RST_PERIPHERAL_ENABLES_ONE;
         receive_status_control_reg  <= RST_RECEIVE_STATUS_CONTROL;
         transmit_status_control_reg  <= RST_TRANSMIT_STATUS_CONTROL;
         baud_reg   <= RST_BAUD_DIVISOR;
      end else if (wr_go) begin
         unique case (idx)
            IDX_INTERRUPT_CONTROL:       interrupt_control_reg <= wbyte;
            IDX_PERIPHERAL_ENABLES_ONE:  pie_reg    <= wbyte;
            IDX_RECEIVE_STATUS_CONTROL:  receive_status_control_reg  <= {wbyte[7:3], 3'b000};
            IDX_TRANSMIT_STATUS_CONTROL: transmit_status_control_reg  <= {wbyte[7:2], 1'b0, wbyte[0]};
            IDX_BAUD_DIVISOR:            baud_reg   <= wbyte;
            default:                     ;
         endcase
      end
   end

   // sleep entered by software, left on any wake event
   always_ff @(posedge clk or negedge resetn) begin
      if (!resetn) begin
         sleep_reg <= 1'b0;
      end else if (wake_reg) begin
         sleep_reg <= 1'b0;
      end else if (wr_go && idx == IDX_POWER_CONTROL) begin
         sleep_reg <= wbyte[BIT_SLEEP];
      end
   end

   // ----------------------------------------------------------------------
   // transmit path
   // ----------------------------------------------------------------------
   // buffer holds one word; a write while full overwrites it
   always_ff @(posedge clk or negedge resetn) begin
      if (!resetn) begin
         txbuf_reg       <= RST_DATA;
         txbuf_ninth_reg <= 1'b0;
         txbuf_full_reg  <= 1'b0;
      end else begin
         if (txbuf_wr) begin
            txbuf_reg       <= wbyte;
            txbuf_ninth_reg <= transmit_status_control_reg[BIT_TX_NINTH];
            txbuf_full_reg  <= 1'b1;
         end else if (tx_load) begin
            txbuf_full_reg  <= 1'b0;  // empty flag rises only here
         end
      end
   end

   // shifter: bit changes after a fall, master samples on its rise
   always_ff @(posedge clk or negedge resetn) begin
      if (!resetn) begin
         tsr_reg      <= 9'h000;
         tx_cnt_reg   <= 4'h0;
         tx_first_reg <= 1'b0;
      end else if (!tx_on) begin
         tx_cnt_reg   <= 4'h0;
         tx_first_reg <= 1'b0;
      end else if (tx_load) begin
         tsr_reg      <= {txbuf_ninth_reg, txbuf_reg};
         tx_cnt_reg   <= nine_tx ? 4'h9 : 4'h8;
         tx_first_reg <= 1'b1;
      end else if (tx_cnt_reg != 4'h0 && ck_edge.fall && !tx_first_reg) begin
         tsr_reg      <= {1'b0, tsr_reg[8:1]};
         tx_cnt_reg   <= tx_cnt_reg - 4'h1;
      end else if (ck_edge.rise) begin
         tx_first_reg <= 1'b0;
      end
   end

   // pin drive follows the shifter, enabled whenever transmit is on
   always_ff @(posedge clk or negedge resetn) begin
      if (!resetn) begin
         data_out_reg <= 1'b0;
         data_oe_reg  <= 1'b0;
      end else begin
         data_out_reg <= tsr_reg[0];
         data_oe_reg  <= tx_on;
      end
   end

   // ----------------------------------------------------------------------
   // receive path
   // ----------------------------------------------------------------------
   logic [3:0] rx_len;
   logic       rx_last;

   assign rx_len   = nine_rx ? 4'h9 : 4'h8;
   // data sampled on the falling edge of the shift clock
   assign rx_last  = rx_on && !overrun_error_reg && ck_edge.fall && rx_cnt_reg == rx_len - 4'h1;
   assign fifo_push = rx_last && !fifo_full;
   assign fifo_word = '{ninth: nine_rx ? dt_level : 1'b0,
                        data:  nine_rx ? rsr_reg[8:1] : {dt_level, rsr_reg[8:2]}};
   assign fifo_pop  = rd_go && idx == IDX_RECEIVE_FIFO_DATA;

   always_ff @(posedge clk or negedge resetn) begin
      if (!resetn) begin
         rsr_reg    <= 9'h000;
         rx_cnt_reg <= 4'h0;
      end else if (!rx_on || overrun_error_reg) begin
         rx_cnt_reg <= 4'h0;
      end else if (ck_edge.fall) begin
         rsr_reg    <= {dt_level, rsr_reg[8:1]};
         rx_cnt_reg <= rx_last ? 4'h0 : rx_cnt_reg + 4'h1;
      end
   end

   // overrun stands until continuous receive is cleared
   always_ff @(posedge clk or negedge resetn) begin
      if (!resetn) begin
         overrun_error_reg <= 1'b0;
         framing_error_reg <= 1'b0;
      end else if (rx_last && fifo_full) begin
         overrun_error_reg <= 1'b1;
      end else if (!receive_status_control_reg[BIT_CONT_RX_EN]) begin
         overrun_error_reg <= 1'b0;
         framing_error_reg <= 1'b0;
      end
   end

   // ----------------------------------------------------------------------
   // wake and vector request
   // ----------------------------------------------------------------------
   logic tx_int;
   logic rx_int;
   logic any_int;

   assign tx_int  = ~txbuf_full_reg & pie_reg[BIT_TX_EMPTY];
   assign rx_int  = ~fifo_empty & pie_reg[BIT_RX_READY];
   assign any_int = (tx_int | rx_int) & interrupt_control_reg[BIT_PERIPH_INT_EN];

   always_ff @(posedge clk or negedge resetn) begin
      if (!resetn) begin
         wake_reg <= 1'b0;
         vec_reg  <= 1'b0;
      end else begin
         wake_reg <= sleep_reg & any_int;
         vec_reg  <= any_int & interrupt_control_reg[BIT_GLOBAL_INT_EN];
      end
   end

   assign data_out       = data_out_reg;
   assign data_oe        = data_oe_reg;
   assign sleeping       = sleep_reg;
   assign wake           = wake_reg;
   assign irq_vector_req = vec_reg;

endmodule

`default_nettype wire

// File: sim/uss_sync_slave_asserts.sv
// Purpose: port checks for the slave serial port
// Assumes: sees only top ports
// Notes:   bind sits after the module
`timescale 1ns/1ps
`default_nettype none
module uss_sync_slave_asserts
   import uss_pkg::*;
(
   input wire logic        clk,
   input wire logic        resetn,
   input wire logic        avs_read,
   input wire logic        avs_write,
   input wire logic [31:0] avs_readdata,
   input wire logic        avs_waitrequest,
   input wire logic        shift_clk_in,
   input wire logic        data_out,
   input wire logic        data_oe,
   input wire logic        sleeping,
   input wire logic        wake
);
   // ----------------------------------------------------------
   // bus handshake, sleep and link checks
   // ----------------------------------------------------------
   default clocking cb @(posedge clk);
   endclocking
   default disable iff (!resetn);

   a_wait_one_cycle: assert property (
      !avs_waitrequest |=> avs_waitrequest)
      else $error("waitrequest low twice");
   a_wait_answer: assert property (
      $rose(avs_read || avs_write) |=> !avs_waitrequest)
      else $error("no answer one cycle after request");
   a_wait_cause: assert property (
      !avs_waitrequest |-> $past(avs_read || avs_write))
      else $error("answer without request");
   a_rdata_upper: assert property (
      !avs_waitrequest |-> avs_readdata[31:8] == 24'h0)
      else $error("upper read data not zero");
   a_wake_after_sleep: assert property (
      wake |-> $past(sleeping))
      else $error("wake while not asleep");
   a_sleep_by_write: assert property (
      $rose(sleeping) |-> $past(avs_write))
      else $error("sleep entered without a write");
   a_oe_by_write: assert property (
      $changed(data_oe) |-> $past(avs_write, 2))
      else $error("drive enable moved without a write");
   // data may only move shortly after a falling shift clock
   a_dout_hold: assert property (
      $rose(shift_clk_in) && !avs_write |=> $stable(data_out)[*4])
      else $error("data moved in high clock phase");
endmodule

bind uss_sync_slave uss_sync_slave_asserts i_uss_sync_slave_asserts (
   .clk(clk), .resetn(resetn), .avs_read(avs_read), .avs_write(avs_write),
   .avs_readdata(avs_readdata), .avs_waitrequest(avs_waitrequest),
   .shift_clk_in(shift_clk_in), .data_out(data_out), .data_oe(data_oe),
   .sleeping(sleeping), .wake(wake));
`default_nettype wire

// File: sim/uss_ext_master.sv
// Purpose: external master that makes the shift clock
// Assumes: idle clock low, one bit per 160 ns
// Notes:   released data line shows the inverse of its last bit
`timescale 1ns/1ps
`default_nettype none
module uss_ext_master
(
   input  wire logic data_out,
   output logic      shift_clk,
   output logic      data_in
);
   // ----------------------------------------------------------
   // frame driver
   // ----------------------------------------------------------
   initial begin
      shift_clk = 1'b0;
      data_in   = 1'b0;
   end

   // lsb first; sample on the rise, device acts on the fall
   task automatic frame(input int n, input logic [8:0] tx, output logic [8:0] rx);
      rx = '0;
      // keep every pin edge off the core clock's rising edges
      #3;
      for (int i = 0; i < n; i++) begin
         #40 data_in = tx[i];
         #40 shift_clk = 1'b1;
         rx[i] = data_out;
         #80 shift_clk = 1'b0;
      end
      #43 data_in = ~data_in;
   endtask
endmodule
`default_nettype wire

// File: sim/tb_uss_sync_slave.sv
// Purpose: self-checking bench for the slave serial port
// Assumes: 100 MHz clk, link clock from the master model
// Notes:   register rows, then sleep and fifo cases
`timescale 1ns/1ps
`default_nettype none
module tb_uss_sync_slave
   import uss_pkg::*;
;
   typedef struct packed {logic we; logic [7:0] idx; logic [7:0] d;} uss_row_t;
   logic        clk, resetn, avs_read, avs_write, avs_waitrequest;
   logic [9:0]  avs_address;
   logic [31:0] avs_writedata, avs_readdata, rd;
   logic        shift_clk_in, data_in, data_out, data_oe, sleeping, wake, irq_vector_req;
   logic [8:0]  rx;
   int          n_errors = 0;
   int          n_compared = 0;
   uss_row_t    rows [10] = '{'{1'b0, 8'h0B, 8'h00}, '{1'b0, 8'h18, 8'h00},
      '{1'b0, 8'h8C, 8'h00}, '{1'b0, 8'h98, 8'h02}, '{1'b0, 8'h99, 8'h00}, '{1'b0, 8'h1A, 8'h00},
      '{1'b1, 8'h99, 8'hA5}, '{1'b0, 8'h99, 8'hA5}, '{1'b1, 8'h20, 8'h5A}, '{1'b0, 8'h20, 8'h00}};

   uss_sync_slave i_uss_sync_slave (.clk(clk), .resetn(resetn), .avs_address(avs_address),
      .avs_read(avs_read), .avs_write(avs_write), .avs_writedata(avs_writedata),
      .avs_byteenable(4'hF), .avs_readdata(avs_readdata), .avs_waitrequest(avs_waitrequest),
      .shift_clk_in(shift_clk_in), .data_in(data_in), .data_out(data_out),
      .data_oe(data_oe), .sleeping(sleeping), .wake(wake), .irq_vector_req(irq_vector_req));
   uss_ext_master i_uss_ext_master (.data_out(data_out), .shift_clk(shift_clk_in),
      .data_in(data_in));

   // ----------------------------------------------------------
   // bus and compare tasks
   // ----------------------------------------------------------
   // request held until waitrequest is sampled low; only the watchdog ends a hang
   task automatic bus(input logic we, input logic [7:0] idx, input logic [7:0] wd);
      @(posedge clk);
      avs_address   <= {idx, 2'b00};
      avs_writedata <= {24'h0, wd};
      avs_write     <= we;
      avs_read      <= !we;
      do begin
         @(posedge clk);
      end while (avs_waitrequest !== 1'b0);
      rd = avs_readdata;
      avs_write <= 1'b0;
      avs_read  <= 1'b0;
   endtask

   task automatic check(input string what, input logic [31:0] exp, input logic [31:0] got);
      n_compared++;
      if (got !== exp) begin
         n_errors++;
         $display("[FAIL] %s expected %h seen %h", what, exp, got);
      end
   endtask

   task automatic results();
      $display("compared %0d mismatches %0d", n_compared, n_errors);
      if (n_errors == 0 && n_compared > 0) $display("No errors found");
      else $display("Errors were found");
      $finish;
   endtask

   // ----------------------------------------------------------
   // clock, watchdog and test sequence
   // ----------------------------------------------------------
   initial begin
      clk = 1'b0;
      forever #5 clk = ~clk;
   end

   // whole run needs well under this span
   initial begin
      #300000;
      n_errors++;
      results();
   end

   initial begin
      resetn = 0; avs_read = 0; avs_write = 0; avs_address = '0; avs_writedata = '0;
      repeat (5) @(posedge clk);
      resetn <= 1'b1;
      foreach (rows[i]) begin
         bus(rows[i].we, rows[i].idx, rows[i].d);
         if (!rows[i].we) check("register", {24'h0, rows[i].d}, rd);
      end
      $display("register rows done");
      bus(1, 8'h18, 8'h80);
      bus(1, 8'h98, 8'h71);
      bus(1, 8'h8C, 8'h10);
      bus(1, 8'h0B, 8'hC0);
      bus(1, 8'h19, 8'h5A);
      check("drive enable", 1, 32'(data_oe));
      i_uss_ext_master.frame(9, 9'h000, rx);
      check("nine bit word", 9'h15A, 32'(rx));
      bus(1, 8'h19, 8'h3C);
      bus(1, 8'h19, 8'hC3);
      bus(1, 8'hF0, 8'h01);
      bus(0, 8'h0C, 8'h00);
      check("empty flag asleep", 0, 32'(rd[4]));
      check("sleeping", 1, 32'(sleeping));
      i_uss_ext_master.frame(9, 9'h000, rx);
      check("first word", 9'h13C, 32'(rx));
      repeat (20) if (wake !== 1'b1) @(posedge clk);
      check("tx wake", 1, 32'(wake));
      repeat (20) if (irq_vector_req !== 1'b1) @(posedge clk);
      check("tx vector", 1, 32'(irq_vector_req));
      bus(0, 8'h0C, 8'h00);
      check("empty flag", 1, 32'(rd[4]));
      i_uss_ext_master.frame(9, 9'h000, rx);
      check("second word", 9'h1C3, 32'(rx));
      $display("transmit cases done");
      bus(1, 8'h8C, 8'h20);
      bus(1, 8'h98, 8'h10);
      bus(1, 8'h18, 8'hE0);
      i_uss_ext_master.frame(9, 9'h1FF, rx);
      bus(0, 8'h0C, 8'h00);
      check("single rx ignored", 0, 32'(rd[5]));
      bus(1, 8'h18, 8'hD0);
      bus(1, 8'hF0, 8'h01);
      i_uss_ext_master.frame(9, 9'h181, rx);
      repeat (20) if (wake !== 1'b1) @(posedge clk);
      check("rx wake", 1, 32'(wake));
      bus(0, 8'h0C, 8'h00);
      check("rx ready", 1, 32'(rd[5]));
      i_uss_ext_master.frame(9, 9'h042, rx);
      i_uss_ext_master.frame(9, 9'h199, rx);
      bus(0, 8'h18, 8'h00);
      check("overrun status", 8'hD3, rd);
      bus(0, 8'h1A, 8'h00);
      check("fifo first", 8'h81, rd);
      bus(0, 8'h18, 8'h00);
      check("next ninth", 8'hD2, rd);
      bus(0, 8'h1A, 8'h00);
      check("fifo second", 8'h42, rd);
      bus(1, 8'h18, 8'hC0);
      bus(0, 8'h18, 8'h00);
      check("error cleared", 8'hC0, rd);
      $display("receive cases done");
      resetn <= 1'b0;
      repeat (2) @(posedge clk);
      resetn <= 1'b1;
      bus(0, 8'h98, 8'h00);
      check("reset transmit status", 8'h02, rd);
      bus(0, 8'h99, 8'h00);
      check("reset divisor", 8'h00, rd);
      $display("mid-run reset case done");
      results();
   end
endmodule
`default_nettype wire
